// *** fbi_pkg.sv ***
package fbi_pkg;
  localparam int CLK_MHZ        = 25;
  localparam int ADDR_W         = 20;
  localparam int DATA_W         = 16;
  localparam int SECT_W         = 6;
  // Times in ns; cycle counts derived at 40 ns per clock.
  localparam int T_ACCESS_NS    = 70;
  localparam int T_SLEEP_EXTRA_NS = 30;
  localparam int T_RP_NS        = 500;
  localparam int T_RH_NS        = 50;
  localparam int T_WP_NS        = 35;
  localparam int T_READY_NS     = 20000;
  localparam int ACC_CYC  = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC   = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int RH_CYC   = (T_RH_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC   = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int READY_CYC = (T_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W    = 10;
  // Write setup spans three cycles so the registered sequence table can catch up.
  localparam int WR_SETUP_CYC = 3;
  // Command codes written on the low byte.
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE   = 8'h80;
  localparam logic [7:0] CMD_CHIP    = 8'h10;
  localparam logic [7:0] CMD_SECTOR  = 8'h30;
  localparam logic [7:0] CMD_RESET   = 8'hf0;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 20'h00555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 20'h002aa;
  typedef enum logic [2:0] {
    FBI_OP_READ, FBI_OP_WRITE, FBI_OP_PROGRAM, FBI_OP_CHIP_ERASE,
    FBI_OP_SECT_ERASE, FBI_OP_AUTOSEL, FBI_OP_RESET_CMD, FBI_OP_HW_RESET
  } fbi_op_e;
endpackage

// *** fbi_seq_if.sv ***
`timescale 1ns/1ps
interface fbi_seq_if;
  import fbi_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic              valid;
  logic              last;
  logic [2:0]        idx;
  modport ctl (output idx, input addr, data, valid, last);
  modport rom (input idx, output addr, data, valid, last);
endinterface

// *** fbi_seq_rom.sv ***
`timescale 1ns/1ps
// Supplies the bus-cycle sequence for each command; a small constant table.
module fbi_seq_rom
  import fbi_pkg::*;
(
  input  wire logic              clk,      // System clock.
  input  wire logic              reset,    // Async reset, active high.
  input  wire fbi_op_e           op,       // Operation latched by controller.
  input  wire logic [ADDR_W-1:0] tgt_addr, // Target or sector address.
  input  wire logic [DATA_W-1:0] tgt_data, // Program data.
  fbi_seq_if.rom                 seq       // Sequence step port.
);
  logic [ADDR_W-1:0] a_d;
  logic [7:0]        c_d;
  logic              l_d;
  logic              v_d;
  logic [DATA_W-1:0] dat_d;

  always_comb begin
    a_d = ADDR_UNLOCK1;
    c_d = CMD_UNLOCK1;
    l_d = 1'b0;
    v_d = 1'b1;
    case (seq.idx)
      3'h0: begin
        if (op == FBI_OP_RESET_CMD) begin
          c_d = CMD_RESET;
          l_d = 1'b1;
        end else if (op == FBI_OP_WRITE) begin
          a_d = tgt_addr;
          l_d = 1'b1;
        end
      end
      3'h1: begin
        a_d = ADDR_UNLOCK2;
        c_d = CMD_UNLOCK2;
      end
      3'h2: begin
        case (op)
          FBI_OP_PROGRAM: c_d = CMD_PROGRAM;
          FBI_OP_AUTOSEL: begin
            c_d = CMD_AUTOSEL;
            l_d = 1'b1;
          end
          default:        c_d = CMD_ERASE;
        endcase
      end
      3'h3: begin
        if (op == FBI_OP_PROGRAM) begin
          a_d = tgt_addr;
          l_d = 1'b1;
        end
      end
      3'h4: begin
        a_d = ADDR_UNLOCK2;
        c_d = CMD_UNLOCK2;
      end
      3'h5: begin
        l_d = 1'b1;
        if (op == FBI_OP_SECT_ERASE) begin
          a_d = tgt_addr;
          c_d = CMD_SECTOR;
        end else begin
          c_d = CMD_CHIP;
        end
      end
      default: v_d = 1'b0;
    endcase
    // A single raw write carries the user's own data, like the program step.
    dat_d = ((op == FBI_OP_PROGRAM && seq.idx == 3'h3) ||
             (op == FBI_OP_WRITE && seq.idx == 3'h0)) ? tgt_data : {8'h00, c_d};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seq.addr  <= '0;
      seq.data  <= '0;
      seq.last  <= 1'b0;
      seq.valid <= 1'b0;
    end else begin
      seq.addr  <= a_d;
      seq.data  <= dat_d;
      seq.last  <= l_d;
      seq.valid <= v_d;
    end
  end
endmodule // fbi_seq_rom

// *** fbi_host_ctrl.sv ***
`timescale 1ns/1ps
// Functional notes
// - Read: chip select, gate low, strobe high.
// - Write: strobe, select low, gate high.
// - Reads during operations return status bits.
// - Host restarts operations a reset interrupted; the controller only flags them on interrupted and does not redo them.
// - Wait recovery time after reset rises.
// - High-voltage pin qualifier enters auto-select.
// - Auto-select reachable through command sequence.
module fbi_host_ctrl
  import fbi_pkg::*;
(
  input  wire logic              clk,          // System clock, 25 MHz.
  input  wire logic              reset,        // Async reset, active high.
  input  wire logic              req_valid,    // Request strobe.
  output logic                   req_ready,    // Controller idle, request taken.
  input  wire fbi_op_e           req_op,       // Requested operation.
  input  wire logic [ADDR_W-1:0] req_addr,     // Address or sector address.
  input  wire logic [DATA_W-1:0] req_data,     // Program data.
  input  wire logic              req_byte,     // One selects byte width.
  input  wire logic              req_id_hv,    // Read with high-voltage qualifier.
  output logic                   rsp_valid,    // Read data valid pulse.
  output logic [DATA_W-1:0]      rsp_data,     // Read data.
  output logic                   busy,         // Device busy or resetting.
  output logic                   interrupted,  // Operation cut by reset; redo it.
  output logic [ADDR_W-1:0]      flash_addr,   // Address pins.
  output logic [DATA_W-1:0]      flash_dq_o,   // Data pins, out.
  output logic                   flash_dq_oe,  // Data pins, drive enable.
  input  wire logic [DATA_W-1:0] flash_dq_i,   // Data pins, in.
  output logic                   flash_ce_n,   // Chip select.
  output logic                   flash_oe_n,   // Output gate.
  output logic                   flash_we_n,   // Write strobe.
  output logic                   width_word,   // Width select, high is word.
  output logic                   flash_reset_n,// Device hardware reset.
  output logic                   id_hv_qual,   // High-voltage qualifier on pin.
  input  wire logic              ready_busy_n  // Device ready, low is busy.
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
    ST_RST_LOW, ST_RST_REC
  } fbi_st_e;

  fbi_st_e          st_q, st_d;
  fbi_op_e          op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic             byte_q, hv_q;
  logic [CNT_W-1:0] cnt_q;
  logic [15:0]      rdy_cnt_q;
  logic [1:0]       rb_sync_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic             active_op_q;
  fbi_seq_if        seq ();
  logic [2:0]       idx_q;

  assign seq.idx = idx_q;

  fbi_seq_rom u_rom (
    .clk      (clk),
    .reset    (reset),
    .op       (op_q),
    .tgt_addr (addr_q),
    .tgt_data (data_q),
    .seq      (seq)
  );

  wire rb_ready  = rb_sync_q[1];
  wire take      = req_valid && req_ready;
  wire cnt_done  = (cnt_q == '0);
  wire is_write_op = (req_op != FBI_OP_READ) && (req_op != FBI_OP_HW_RESET);

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n - 1);
  endfunction

  assign req_ready = (st_q == ST_IDLE);
  // Bus pins derived from state so that read and write never overlap.
  assign flash_ce_n = !(st_q inside {ST_RD_SETUP, ST_RD_WAIT, ST_WR_PULSE});
  assign flash_oe_n = !(st_q inside {ST_RD_SETUP, ST_RD_WAIT});
  assign flash_we_n = (st_q != ST_WR_PULSE);
  assign flash_dq_oe = (st_q inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD});
  assign flash_reset_n = (st_q != ST_RST_LOW);
  assign width_word = !byte_q;
  assign id_hv_qual = hv_q && (st_q inside {ST_RD_SETUP, ST_RD_WAIT});
  assign busy = !rb_ready || (st_q inside {ST_RST_LOW, ST_RST_REC});

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (take) begin
          if (req_op == FBI_OP_HW_RESET)
            st_d = ST_RST_LOW;
          else if (is_write_op)
            st_d = ST_WR_SETUP;
          else
            st_d = ST_RD_SETUP;
        end
      end
      ST_RD_SETUP: st_d = ST_RD_WAIT;
      ST_RD_WAIT:  if (cnt_done) st_d = ST_IDLE;
      ST_WR_SETUP: if (cnt_done) st_d = ST_WR_PULSE;
      ST_WR_PULSE: if (cnt_done) st_d = ST_WR_HOLD;
      ST_WR_HOLD:  st_d = seq.last ? ST_IDLE : ST_WR_SETUP;
      ST_RST_LOW:  if (cnt_done) st_d = ST_RST_REC;
      ST_RST_REC:  if (cnt_done) st_d = ST_IDLE;
      default:     st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rb_sync_q <= 2'b11;
      dq_s1_q   <= '0;
      dq_s2_q   <= '0;
    end else begin
      rb_sync_q <= {rb_sync_q[0], ready_busy_n};
      dq_s1_q   <= flash_dq_i;
      dq_s2_q   <= dq_s1_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      op_q <= FBI_OP_READ;
      addr_q <= '0;
      data_q <= '0;
      byte_q <= 1'b0;
      hv_q <= 1'b0;
      idx_q <= 3'h0;
    end else begin
      st_q <= st_d;
      if (take) begin
        op_q   <= req_op;
        addr_q <= req_addr;
        data_q <= req_data;
        byte_q <= req_byte;
        hv_q   <= req_id_hv && (req_op == FBI_OP_READ);
        idx_q  <= 3'h0;
      end else if (st_q == ST_WR_HOLD) begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (st_d != st_q) begin
      case (st_d)
        ST_RD_WAIT:  cnt_q <= cyc(ACC_CYC + 2); // Covers the input synchroniser.
        ST_WR_SETUP: cnt_q <= cyc(WR_SETUP_CYC);
        ST_WR_PULSE: cnt_q <= cyc(WP_CYC);
        ST_RST_LOW:  cnt_q <= cyc(RP_CYC);
        ST_RST_REC:  cnt_q <= cyc(RH_CYC);
        default:     cnt_q <= '0;
      endcase
    end else if (!cnt_done) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // Address and data held through the whole cycle; address stays put so
  // the device may sleep yet still show the last data.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_addr <= '0;
      flash_dq_o <= '0;
    end else if (st_d == ST_RD_SETUP) begin
      flash_addr <= req_addr;
    end else if (st_q == ST_WR_SETUP && cnt_q == CNT_W'(1) && seq.valid) begin
      // The table answers one cycle after the step index moves, so the pins
      // load in the middle setup cycle and still get a full cycle of setup.
      flash_addr <= seq.addr;
      flash_dq_o <= byte_q ? {8'h00, seq.data[7:0]} : seq.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= (st_q == ST_RD_WAIT) && cnt_done;
      if ((st_q == ST_RD_WAIT) && cnt_done)
        rsp_data <= byte_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
    end
  end

  // A reset that lands while the device is busy loses the operation.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_op_q <= 1'b0;
      interrupted <= 1'b0;
      rdy_cnt_q   <= '0;
    end else begin
      if (st_q == ST_WR_HOLD && seq.last &&
          op_q inside {FBI_OP_PROGRAM, FBI_OP_CHIP_ERASE, FBI_OP_SECT_ERASE})
        active_op_q <= 1'b1;
      else if (rb_ready && rdy_cnt_q == 16'h0000 && st_q == ST_IDLE)
        active_op_q <= 1'b0;
      if (st_q == ST_WR_HOLD && seq.last)
        rdy_cnt_q <= 16'h0004;
      else if (rdy_cnt_q != 16'h0000)
        rdy_cnt_q <= rdy_cnt_q - 16'h0001;
      if (st_q == ST_RST_LOW && active_op_q)
        interrupted <= 1'b1;
      else if (take && req_op != FBI_OP_HW_RESET)
        interrupted <= 1'b0;
    end
  end
endmodule // fbi_host_ctrl

// *** fbi_host_ctrl_properties.sv ***
`timescale 1ns/1ps
module fbi_host_ctrl_properties
  import fbi_pkg::*;
(
  input wire logic              clk,           // Clock.
  input wire logic              reset,         // Reset.
  input wire logic              busy,          // Busy.
  input wire logic [ADDR_W-1:0] flash_addr,    // Address.
  input wire logic [DATA_W-1:0] flash_dq_o,    // Data out.
  input wire logic              flash_dq_oe,   // Data enable.
  input wire logic              flash_ce_n,    // Select.
  input wire logic              flash_oe_n,    // Gate.
  input wire logic              flash_we_n,    // Strobe.
  input wire logic              flash_reset_n, // Device reset.
  input wire logic              ready_busy_n   // Busy pin.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [CNT_W-1:0] low_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) low_q <= '0;
    else if (flash_reset_n) low_q <= '0;
    else low_q <= low_q + 1'b1;
  end
  property p_rd; !flash_oe_n |-> flash_we_n && !flash_ce_n; endproperty
  a_rd: assert property (p_rd) else $error("gate low outside read");
  property p_wr; !flash_we_n |-> flash_oe_n && !flash_ce_n && flash_dq_oe; endproperty
  a_wr: assert property (p_wr) else $error("bad write strobes");
  property p_fl; flash_dq_oe |-> flash_oe_n; endproperty
  a_fl: assert property (p_fl) else $error("bus fight");
  // The first edge after our own reset is skipped: the pulse may predate it.
  property p_rp; $rose(flash_reset_n) && !$past(reset) |-> low_q >= RP_CYC; endproperty
  a_rp: assert property (p_rp) else $error("reset pulse short");
  property p_rh; $rose(flash_reset_n) |-> flash_ce_n [*2]; endproperty
  a_rh: assert property (p_rh) else $error("no recovery");
  property p_qt; !flash_reset_n |-> flash_ce_n && flash_we_n; endproperty
  a_qt: assert property (p_qt) else $error("access in reset");
  property p_hd; !flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_o); endproperty
  a_hd: assert property (p_hd) else $error("write bus moved");
  property p_hx; $rose(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_o); endproperty
  a_hx: assert property (p_hx) else $error("write hold broken");
  property p_sb; flash_ce_n |-> flash_oe_n && flash_we_n; endproperty
  a_sb: assert property (p_sb) else $error("strobe while deselected");
  property p_by; !ready_busy_n [*3] |-> busy; endproperty
  a_by: assert property (p_by) else $error("busy missed");
endmodule // fbi_host_ctrl_properties
bind fbi_host_ctrl fbi_host_ctrl_properties u_chk (.clk, .reset, .busy, .flash_addr,
  .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
  .ready_busy_n);

// *** fbi_flash_model.sv ***
`timescale 1ns/1ps
module fbi_flash_model
  import fbi_pkg::*;
#(
  parameter logic [15:0] MFR_ID = 16'h00c3, // Arbitrary value.
  parameter logic [15:0] DEV_ID = 16'h2a7e  // Arbitrary value.
) (
  input  wire logic              clk,           // Clock.
  input  wire logic [ADDR_W-1:0] flash_addr,    // Address.
  input  wire logic [DATA_W-1:0] flash_dq_o,    // Host data.
  input  wire logic              flash_dq_oe,   // Host drive.
  output logic      [DATA_W-1:0] flash_dq_i,    // Bus level.
  input  wire logic              flash_ce_n,    // Select.
  input  wire logic              flash_oe_n,    // Gate.
  input  wire logic              flash_we_n,    // Strobe.
  input  wire logic              width_word,    // Width.
  input  wire logic              flash_reset_n, // Reset.
  input  wire logic              id_hv_qual,    // Id qualifier.
  output logic                   ready_busy_n   // Busy pin.
);
  logic [15:0] mem [256];
  logic [15:0] last_q, rv, pd, cd;
  logic [19:0] pa, ca;
  logic [1:0]  kind;
  logic [2:0]  st = 3'd0;
  logic        asel = 1'b0, wr_q = 1'b0;
  int          cnt = 0;
  wire wr = !flash_we_n && !flash_ce_n && flash_oe_n && flash_reset_n;
  wire rd = !flash_ce_n && !flash_oe_n && flash_we_n && flash_reset_n;
  wire [7:0] ix = {flash_addr[19:16], flash_addr[3:0]};
  assign ready_busy_n = cnt == 0;
  assign rv = cnt != 0 ? {8'h00, ~pd[7], cnt[0], 6'h00} :
    (asel || id_hv_qual) ? (flash_addr[0] ? DEV_ID : MFR_ID) : mem[ix];
  // A released bus shows the inverse of its last level, never a held copy.
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : !rd ? ~last_q :
    width_word ? rv : {~last_q[15:8], rv[7:0]};
  initial foreach (mem[i]) mem[i] = 16'hffff;
  always @(posedge clk) begin
    last_q <= flash_dq_i;
    wr_q <= wr;
    if (wr) {ca, cd} <= {flash_addr, flash_dq_o};
    if (!flash_reset_n) begin
      {st, asel} <= '0;
      if (cnt != 0) {kind, cnt} <= {2'd0, 32'd2};
    end else if (cnt == 1) begin
      cnt <= 0;
      foreach (mem[i]) begin
        if (kind == 2 || (kind == 3 && i[7:4] == pa[19:16])) mem[i] <= 16'hffff;
      end
      if (kind == 1) mem[{pa[19:16], pa[3:0]}] <= pd;
    end else if (cnt != 0) cnt <= cnt - 1;
    else if (wr_q && !wr) begin
      st <= 0;
      if (cd[7:0] == CMD_RESET) asel <= 1'b0;
      else if (st == 3) {pa, pd, kind, cnt} <= {ca, cd, 2'd1, 32'd30};
      else if (st == 6 && cd[7:0] == CMD_CHIP) {kind, cnt} <= {2'd2, 32'd30};
      else if (st == 6 && cd[7:0] == CMD_SECTOR) {pa, kind, cnt} <= {ca, 2'd3, 32'd30};
      else if (st[1:0] == 0 && ca == ADDR_UNLOCK1 && cd[7:0] == CMD_UNLOCK1) st <= st + 1;
      else if (st[1:0] == 1 && ca == ADDR_UNLOCK2 && cd[7:0] == CMD_UNLOCK2) st <= st + 1;
      else if (st == 2) begin
        asel <= cd[7:0] == CMD_AUTOSEL;
        st <= cd[7:0] == CMD_PROGRAM ? 3'd3 : cd[7:0] == CMD_ERASE ? 3'd4 : 3'd0;
      end
    end
  end
endmodule // fbi_flash_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import fbi_pkg::*;
  logic        clk, reset, req_valid, req_ready, req_byte, req_id_hv, rsp_valid, busy;
  logic        interrupted, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, width_word;
  logic        flash_reset_n, id_hv_qual, ready_busy_n;
  fbi_op_e     req_op;
  logic [19:0] req_addr, flash_addr, a [4];
  logic [15:0] req_data, rsp_data, flash_dq_o, flash_dq_i, got, dx, d [4];
  int          n_errors = 0;
  int          compares = 0;
  fbi_host_ctrl dut (.clk, .reset, .req_valid, .req_ready, .req_op, .req_addr, .req_data,
    .req_byte, .req_id_hv, .rsp_valid, .rsp_data, .busy, .interrupted, .flash_addr,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .width_word, .flash_reset_n, .id_hv_qual, .ready_busy_n);
  fbi_flash_model #(.MFR_ID(16'h00c3), .DEV_ID(16'h2a7e)) u_dev (.clk, .flash_addr,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .width_word, .flash_reset_n, .id_hv_qual, .ready_busy_n);
  task automatic results();
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] lo_byte(logic [15:0] v);
    return {8'h00, v[7:0]};
  endfunction
  // Handshake outputs are looked at 1 ns after the edge, once they have settled.
  task automatic run(fbi_op_e op, logic [19:0] ad, logic [15:0] dt = 0, logic b = 0,
                     logic hv = 0);
    got = 'x;
    req_op = op;
    {req_addr, req_data, req_byte, req_id_hv, req_valid} = {ad, dt, b, hv, 1'b1};
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
    repeat (400) begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) got = rsp_data;
      if (req_ready === 1'b1) break;
    end
  endtask
  // The busy pin passes a synchroniser, so a few cycles go by before it shows.
  task automatic idle();
    repeat (4) @(posedge clk);
    #1;
    repeat (400) begin
      if (busy === 1'b0) break;
      @(posedge clk);
      #1;
    end
    chk({15'h0, busy}, 16'h0000);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED %0t watchdog", $time);
    results();
  end
  initial begin
    reset = 1'b1;
    req_op = FBI_OP_READ;
    {req_addr, req_data, req_byte, req_id_hv, req_valid} = '0;
    void'($urandom(32'h7baf750b));
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    run(FBI_OP_READ, 20'h00003);
    chk(got, 16'hffff);
    for (int k = 0; k < 4; k++) begin
      a[k] = {4'(k), 12'h000, 4'($urandom)};
      d[k] = k == 0 ? 16'h80ff : 16'($urandom);
      run(FBI_OP_PROGRAM, a[k], d[k]);
      idle();
      run(FBI_OP_READ, a[k]);
      chk(got, d[k]);
      run(FBI_OP_READ, a[k], 0, 1'b1);
      chk(got, lo_byte(d[k]));
    end
    dx = 16'($urandom);
    run(FBI_OP_PROGRAM, 20'hf0005, dx);
    run(FBI_OP_HW_RESET, 20'h0);
    chk({15'h0, interrupted}, 16'h0001);
    idle();
    run(FBI_OP_READ, 20'hf0005);
    chk(got, 16'hffff);
    run(FBI_OP_PROGRAM, 20'hf0005, dx);
    run(FBI_OP_READ, 20'hf0005);
    chk({15'h0, got[7]}, {15'h0, ~dx[7]});
    idle();
    run(FBI_OP_READ, 20'hf0005);
    chk(got, dx);
    run(FBI_OP_SECT_ERASE, a[0]);
    idle();
    run(FBI_OP_READ, a[0]);
    chk(got, 16'hffff);
    run(FBI_OP_READ, a[1]);
    chk(got, d[1]);
    run(FBI_OP_AUTOSEL, 20'h0);
    run(FBI_OP_READ, 20'h0);
    chk(got, 16'h00c3);
    run(FBI_OP_RESET_CMD, 20'h0);
    run(FBI_OP_WRITE, ADDR_UNLOCK1, {8'h00, CMD_UNLOCK1});
    run(FBI_OP_WRITE, 20'h00123, 16'h0000);
    run(FBI_OP_READ, a[2]);
    chk(got, d[2]);
    run(FBI_OP_READ, 20'h00001, 0, 1'b0, 1'b1);
    chk(got, 16'h2a7e);
    run(FBI_OP_CHIP_ERASE, 20'h0);
    idle();
    run(FBI_OP_READ, a[2]);
    chk(got, 16'hffff);
    results();
  end
endmodule // testbench
